// ==== rta_pkg.sv ====
// constants shared by the alarm block and its compare unit
`default_nettype none

package rta_pkg;

    // ------------------------------------------------------------
    // register addresses on the serial link
    // ------------------------------------------------------------
    localparam logic [3:0] RTA_ADDR_MIN_ALARM = 4'h8;
    localparam logic [3:0] RTA_ADDR_HOUR_ALARM = 4'h9;
    localparam logic [3:0] RTA_ADDR_WD_ALARM = 4'hA;
    localparam logic [3:0] RTA_ADDR_EXTENSION = 4'hD;
    localparam logic [3:0] RTA_ADDR_FLAG = 4'hE;
    localparam logic [3:0] RTA_ADDR_CONTROL = 4'hF;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int RTA_EXCLUDE_BIT = 7;
    localparam int RTA_SELECT_BIT = 6;
    localparam int RTA_FLAG_BIT = 3;
    localparam int RTA_IRQEN_BIT = 3;
    localparam int RTA_SWRST_BIT = 0;
    localparam int RTA_CTRL_ZERO_BIT = 1;
    localparam int RTA_LAST_BIT = 7;

    // ------------------------------------------------------------
    // header command nibble
    // ------------------------------------------------------------
    localparam logic [3:0] RTA_CMD_WRITE = 4'h0;
    localparam logic [3:0] RTA_CMD_READ = 4'hC;

    // ------------------------------------------------------------
    // reset values and widths
    // ------------------------------------------------------------
    localparam logic [7:0] RTA_ALARM_RESET = 8'h00;
    localparam logic [7:0] RTA_EXT_RESET = 8'h00;
    localparam logic [7:0] RTA_CTRL_RESET = 8'h00;
    localparam logic [7:0] RTA_READ_ZERO = 8'h00;
    localparam logic [2:0] RTA_LAST_COUNT = 3'h7;
    localparam logic [2:0] RTA_COUNT_ZERO = 3'h0;
    localparam logic [3:0] RTA_ADDR_STEP = 4'h1;
    localparam logic [3:0] RTA_ADDR_ZERO = 4'h0;

endpackage

`default_nettype wire

// ==== rta_match_if.sv ====
// carrier between the register side and the compare unit
`default_nettype none

interface rta_match_if;
    logic [7:0] min_tgt;
    logic [7:0] hour_tgt;
    logic [7:0] wd_tgt;
    logic date_sel;
    logic [6:0] cur_minute;
    logic [5:0] cur_hour;
    logic [2:0] cur_weekday;
    logic [5:0] cur_date;
    logic match;

    modport src (
        output min_tgt,
        output hour_tgt,
        output wd_tgt,
        output date_sel,
        output cur_minute,
        output cur_hour,
        output cur_weekday,
        output cur_date,
        input match
    );

    modport chk (
        input min_tgt,
        input hour_tgt,
        input wd_tgt,
        input date_sel,
        input cur_minute,
        input cur_hour,
        input cur_weekday,
        input cur_date,
        output match
    );
endinterface

`default_nettype wire

// ==== rta_match.sv ====
// alarm compare unit: targets against the running time
`default_nettype none

module rta_match (
    rta_match_if.chk m
);

    // ------------------------------------------------------------
    // weekday bitmap lookup, sunday at bit 0
    // ------------------------------------------------------------
    function automatic logic rta_day_hit(input logic [7:0] map,
                                         input logic [2:0] day);
        logic hit;
        hit = 1'b0;
        // weekday code 7 never hits, it would land on the exclude bit
        if (day != rta_pkg::RTA_LAST_COUNT) begin
            hit = map[day];
        end
        return hit;
    endfunction

    logic min_ok;
    logic hour_ok;
    logic day_ok;

    // ------------------------------------------------------------
    // per-register compare with exclusion
    // ------------------------------------------------------------
    always_comb begin
        min_ok = m.min_tgt[rta_pkg::RTA_EXCLUDE_BIT] |
                 (m.min_tgt[6:0] == m.cur_minute);
        hour_ok = m.hour_tgt[rta_pkg::RTA_EXCLUDE_BIT] |
                  (m.hour_tgt[5:0] == m.cur_hour);
        if (m.wd_tgt[rta_pkg::RTA_EXCLUDE_BIT]) begin
            day_ok = 1'b1;
        end else if (m.date_sel) begin
            day_ok = m.wd_tgt[5:0] == m.cur_date;
        end else begin
            day_ok = rta_day_hit(m.wd_tgt, m.cur_weekday);
        end
    end

    assign m.match = min_ok & hour_ok & day_ok;

endmodule

`default_nettype wire

// ==== rta_top.sv ====
// alarm match and interrupt block with its serial register port
`default_nettype none

module rta_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    input wire logic minute_tick,
    input wire logic [6:0] cur_minute,
    input wire logic [5:0] cur_hour,
    input wire logic [2:0] cur_weekday,
    input wire logic [5:0] cur_date,
    input wire logic other_int_low,
    output logic int_o,
    output logic int_oe
);

    typedef enum logic [1:0] {
        RTA_IDLE,
        RTA_HEAD,
        RTA_DATA
    } rta_state_e;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rta_state_e state;
    rta_state_e next_state;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic [7:0] rx;
    logic [7:0] next_rx;
    logic [7:0] tx;
    logic [7:0] next_tx;
    logic [3:0] addr;
    logic [3:0] next_addr;
    logic is_read;
    logic next_is_read;
    logic is_write;
    logic next_is_write;
    logic sclk_q;

    logic [7:0] min_tgt;
    logic [7:0] next_min_tgt;
    logic [7:0] hour_tgt;
    logic [7:0] next_hour_tgt;
    logic [7:0] wd_tgt;
    logic [7:0] next_wd_tgt;
    logic [7:0] ext_reg;
    logic [7:0] next_ext_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] next_ctrl_reg;
    logic alarm_flag;
    logic next_alarm_flag;

    logic next_sdo;
    logic next_sdo_oe;
    logic next_int_oe;

    logic sclk_rise;
    logic [7:0] in_byte;
    logic wr_en;
    logic [3:0] wr_addr;
    logic alarm_event;

    rta_match_if mif ();

    // ------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------
    function automatic logic [7:0] rta_read(input logic [3:0] a,
                                            input logic [7:0] r_min,
                                            input logic [7:0] r_hour,
                                            input logic [7:0] r_wd,
                                            input logic [7:0] r_ext,
                                            input logic r_flag,
                                            input logic [7:0] r_ctrl);
        logic [7:0] d;
        d = rta_pkg::RTA_READ_ZERO;
        unique case (a)
            rta_pkg::RTA_ADDR_MIN_ALARM: d = r_min;
            rta_pkg::RTA_ADDR_HOUR_ALARM: d = r_hour;
            rta_pkg::RTA_ADDR_WD_ALARM: d = r_wd;
            rta_pkg::RTA_ADDR_EXTENSION: d = r_ext;
            rta_pkg::RTA_ADDR_FLAG: d[rta_pkg::RTA_FLAG_BIT] = r_flag;
            rta_pkg::RTA_ADDR_CONTROL: d = r_ctrl;
            default: d = rta_pkg::RTA_READ_ZERO;
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------
    // compare unit hookup
    // ------------------------------------------------------------
    assign mif.min_tgt = min_tgt;
    assign mif.hour_tgt = hour_tgt;
    assign mif.wd_tgt = wd_tgt;
    assign mif.date_sel = ext_reg[rta_pkg::RTA_SELECT_BIT];
    assign mif.cur_minute = cur_minute;
    assign mif.cur_hour = cur_hour;
    assign mif.cur_weekday = cur_weekday;
    assign mif.cur_date = cur_date;

    rta_match u_match (
        .m(mif.chk)
    );

    // only the minute update samples the compare
    assign alarm_event = minute_tick & mif.match &
                         ~ctrl_reg[rta_pkg::RTA_SWRST_BIT];

    assign sclk_rise = sclk & ~sclk_q;
    assign in_byte = {rx[6:0], sdi};

    // ------------------------------------------------------------
    // serial framing, next values
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_rx = rx;
        next_tx = tx;
        next_addr = addr;
        next_is_read = is_read;
        next_is_write = is_write;
        wr_en = 1'b0;
        wr_addr = addr;
        if (!ce) begin
            // partial byte is dropped when the frame ends
            next_state = RTA_IDLE;
            next_bit_cnt = rta_pkg::RTA_COUNT_ZERO;
            next_is_read = 1'b0;
            next_is_write = 1'b0;
        end else begin
            unique case (state)
                RTA_IDLE: begin
                    next_state = RTA_HEAD;
                    next_bit_cnt = rta_pkg::RTA_COUNT_ZERO;
                end
                RTA_HEAD: begin
                    if (sclk_rise) begin
                        next_rx = in_byte;
                        next_bit_cnt = 3'(bit_cnt + 3'h1);
                        if (bit_cnt == rta_pkg::RTA_LAST_COUNT) begin
                            next_state = RTA_DATA;
                            next_addr = in_byte[7:4];
                            next_is_read =
                                in_byte[3:0] == rta_pkg::RTA_CMD_READ;
                            next_is_write =
                                in_byte[3:0] == rta_pkg::RTA_CMD_WRITE;
                            next_tx = rta_read(in_byte[7:4], min_tgt,
                                               hour_tgt, wd_tgt, ext_reg,
                                               alarm_flag, ctrl_reg);
                        end
                    end
                end
                RTA_DATA: begin
                    if (sclk_rise) begin
                        next_rx = in_byte;
                        next_bit_cnt = 3'(bit_cnt + 3'h1);
                        if (bit_cnt == rta_pkg::RTA_LAST_COUNT) begin
                            wr_en = is_write;
                            next_addr = addr + rta_pkg::RTA_ADDR_STEP;
                            if (is_read) begin
                                next_tx = rta_read(next_addr, min_tgt,
                                                   hour_tgt, wd_tgt,
                                                   ext_reg, alarm_flag,
                                                   ctrl_reg);
                            end
                        end else if (is_read) begin
                            next_tx = {tx[6:0], 1'b0};
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // register file and flag, next values
    // ------------------------------------------------------------
    always_comb begin
        next_min_tgt = min_tgt;
        next_hour_tgt = hour_tgt;
        next_wd_tgt = wd_tgt;
        next_ext_reg = ext_reg;
        next_ctrl_reg = ctrl_reg;
        next_alarm_flag = alarm_flag;
        if (wr_en) begin
            unique case (wr_addr)
                rta_pkg::RTA_ADDR_MIN_ALARM: next_min_tgt = in_byte;
                rta_pkg::RTA_ADDR_HOUR_ALARM: next_hour_tgt = in_byte;
                rta_pkg::RTA_ADDR_WD_ALARM: next_wd_tgt = in_byte;
                rta_pkg::RTA_ADDR_EXTENSION: next_ext_reg = in_byte;
                rta_pkg::RTA_ADDR_FLAG: begin
                    if (!in_byte[rta_pkg::RTA_FLAG_BIT]) begin
                        next_alarm_flag = 1'b0;
                    end
                end
                rta_pkg::RTA_ADDR_CONTROL: begin
                    next_ctrl_reg = in_byte;
                    next_ctrl_reg[rta_pkg::RTA_CTRL_ZERO_BIT] = 1'b0;
                end
                default: begin
                end
            endcase
        end
        // a new event outranks a clear in the same cycle
        if (alarm_event) begin
            next_alarm_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // pin drivers, next values
    // ------------------------------------------------------------
    always_comb begin
        next_sdo = tx[rta_pkg::RTA_LAST_BIT];
        next_sdo_oe = ce & (state == RTA_DATA) & is_read;
        // pin stays low while both flag and enable hold, or while other_int_low is high
        next_int_oe = (alarm_flag & ctrl_reg[rta_pkg::RTA_IRQEN_BIT]) |
                      other_int_low;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= RTA_IDLE;
            bit_cnt <= rta_pkg::RTA_COUNT_ZERO;
            rx <= rta_pkg::RTA_READ_ZERO;
            tx <= rta_pkg::RTA_READ_ZERO;
            addr <= rta_pkg::RTA_ADDR_ZERO;
            is_read <= 1'b0;
            is_write <= 1'b0;
            sclk_q <= 1'b0;
            min_tgt <= rta_pkg::RTA_ALARM_RESET;
            hour_tgt <= rta_pkg::RTA_ALARM_RESET;
            wd_tgt <= rta_pkg::RTA_ALARM_RESET;
            ext_reg <= rta_pkg::RTA_EXT_RESET;
            ctrl_reg <= rta_pkg::RTA_CTRL_RESET;
            alarm_flag <= 1'b0;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
            int_o <= 1'b0;
            int_oe <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            rx <= next_rx;
            tx <= next_tx;
            addr <= next_addr;
            is_read <= next_is_read;
            is_write <= next_is_write;
            sclk_q <= sclk;
            min_tgt <= next_min_tgt;
            hour_tgt <= next_hour_tgt;
            wd_tgt <= next_wd_tgt;
            ext_reg <= next_ext_reg;
            ctrl_reg <= next_ctrl_reg;
            alarm_flag <= next_alarm_flag;
            sdo <= next_sdo;
            sdo_oe <= next_sdo_oe;
            int_o <= 1'b0;
            int_oe <= next_int_oe;
        end
    end

endmodule

`default_nettype wire

// ==== rta_end.sv ====
// end marker file holding no logic
`default_nettype none
`default_nettype wire

// ==== rta_checker.sv ====
// pin-level assertions for the alarm block
`default_nettype none

module rta_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic sclk,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic minute_tick,
    input wire logic other_int_low,
    input wire logic int_o,
    input wire logic int_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_open_drain: assert property (
        int_o == 1'b0) else $error("pin data not low");
    a_other_low: assert property (
        other_int_low |=> int_oe) else $error("shared source lost");
    a_rise_cause: assert property (
        $rose(int_oe) |-> $past(minute_tick, 2) || other_int_low
            || $past(other_int_low) || $past(ce))
        else $error("pin low without cause");
    a_hold_low: assert property (
        int_oe && !other_int_low && !$past(other_int_low) && !$past(ce)
            |=> int_oe) else $error("pin released early");
    a_fall_cause: assert property (
        $fell(int_oe) |-> $past(other_int_low) || $past(other_int_low, 2)
            || $past(ce, 2)) else $error("pin released without write");
    a_sdo_ce: assert property (
        sdo_oe |-> $past(ce)) else $error("sdo driven outside frame");
    a_sdo_steady: assert property (
        sdo_oe && $past(sdo_oe) && !sclk && !$past(sclk) && !$past(sclk, 2)
            |-> $stable(sdo)) else $error("sdo moved in low phase");
    a_reset_quiet: assert property (
        $rose(rst_b) |-> !int_oe && !sdo_oe) else $error("outputs busy");

    c_fire: cover property ($rose(int_oe) && $past(minute_tick, 2));
    c_free: cover property ($fell(int_oe));
    c_read: cover property ($rose(sdo_oe));
endmodule

bind rta_top rta_checker i_chk (.clk(clk), .rst_b(rst_b), .ce(ce),
    .sclk(sclk), .sdo(sdo), .sdo_oe(sdo_oe), .minute_tick(minute_tick),
    .other_int_low(other_int_low), .int_o(int_o), .int_oe(int_oe));

`default_nettype wire

// ==== rta_host.sv ====
// host model for the serial register link
`default_nettype none

module rta_host (
    input wire logic clk,
    output logic ce,
    output logic sclk,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] buf_q [4];

    initial {ce, sclk, sdi} = 3'h0;

    // data set while low, reply taken just before the rise
    task automatic bit_x(input logic d, output logic q);
        repeat (3) @(negedge clk);
        q = sdo_oe ? sdo : 1'bx;
        sdi = (d === 1'b1);
        sclk = 1'b1;
        repeat (3) @(negedge clk);
        sclk = 1'b0;
    endtask

    task automatic xfer(input logic [3:0] a, input logic [3:0] c,
                        input int n);
        logic q;
        @(negedge clk);
        ce = 1'b1;
        for (int i = 7; i >= 0; i--)
            bit_x(i > 3 ? a[i - 4] : c[i], q);
        for (int b = 0; b < n; b++)
            for (int i = 7; i >= 0; i--) begin
                bit_x(buf_q[b][i], q);
                buf_q[b][i] = q;
            end
        repeat (3) @(negedge clk);
        ce = 1'b0;
        sdi = ~sdi;
        repeat (2) @(negedge clk);
    endtask
endmodule

`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the alarm match block
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst_b, ce, sclk, sdi, sdo, sdo_oe, int_o, int_oe;
    logic minute_tick, other_int_low;
    logic [6:0] cur_minute;
    logic [5:0] cur_hour, cur_date;
    logic [2:0] cur_weekday;
    int n_mismatch = 0;
    int compares = 0;

    rta_top i_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .sclk(sclk),
        .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .minute_tick(minute_tick),
        .cur_minute(cur_minute), .cur_hour(cur_hour),
        .cur_weekday(cur_weekday), .cur_date(cur_date),
        .other_int_low(other_int_low), .int_o(int_o), .int_oe(int_oe));
    rta_host i_host (.clk(clk), .ce(ce), .sclk(sclk), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic irq(input logic e);
        chk({7'h00, int_oe}, {7'h00, e});
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_host.buf_q[0] = d;
        i_host.xfer(a, rta_pkg::RTA_CMD_WRITE, 1);
    endtask

    task automatic flag(input logic e);
        i_host.xfer(4'hE, rta_pkg::RTA_CMD_READ, 1);
        chk(i_host.buf_q[0], {4'h0, e, 3'h0});
    endtask

    task automatic tgt(input logic [7:0] m, h, w);
        i_host.buf_q = '{m, h, w, 8'h00};
        i_host.xfer(4'h8, rta_pkg::RTA_CMD_WRITE, 3);
    endtask

    task automatic tick(input logic [21:0] t);
        @(negedge clk);
        {cur_minute, cur_hour, cur_weekday, cur_date} = t;
        minute_tick = 1'b1;
        @(negedge clk);
        minute_tick = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic sc_regs;
        tgt(8'h59, 8'hD8, 8'h55);
        i_host.buf_q[0] = 8'h11;
        i_host.xfer(4'h8, 4'h5, 1);
        i_host.xfer(4'h8, rta_pkg::RTA_CMD_READ, 4);
        chk(i_host.buf_q[0], 8'h59);
        chk(i_host.buf_q[1], 8'hD8);
        chk(i_host.buf_q[2], 8'h55);
        chk(i_host.buf_q[3], 8'h00);
        i_host.buf_q = '{8'hC2, 8'h77, 8'h00, 8'h00};
        i_host.xfer(4'hF, rta_pkg::RTA_CMD_WRITE, 2);
        i_host.xfer(4'hF, rta_pkg::RTA_CMD_READ, 2);
        chk(i_host.buf_q[0], 8'hC0);
        chk(i_host.buf_q[1], 8'h00);
    endtask

    task automatic sc_week;
        tgt(8'h30, 8'h12, 8'h22);
        wr(4'hD, 8'h00);
        wr(4'hF, 8'h08);
        tick({7'h30, 6'h12, 3'h2, 6'h22});
        irq(1'b0);
        tick({7'h31, 6'h12, 3'h1, 6'h01});
        irq(1'b0);
        tick({7'h30, 6'h12, 3'h5, 6'h01});
        irq(1'b1);
        flag(1'b1);
        wr(4'hE, 8'h00);
        irq(1'b0);
        repeat (20) @(negedge clk);
        flag(1'b0);
    endtask

    task automatic sc_date;
        wr(4'hD, 8'h40);
        wr(4'hA, 8'h55);
        tick({7'h30, 6'h12, 3'h0, 6'h14});
        irq(1'b0);
        tick({7'h30, 6'h12, 3'h1, 6'h15});
        irq(1'b1);
        wr(4'hE, 8'h00);
        wr(4'hA, 8'h80);
        tick({7'h30, 6'h12, 3'h3, 6'h09});
        irq(1'b1);
        wr(4'hE, 8'h00);
        tgt(8'h80, 8'h80, 8'h80);
        for (int i = 1; i < 3; i++) begin
            tick({7'(i), 6'h00, 3'h6, 6'h31});
            irq(1'b1);
            wr(4'hE, 8'h00);
        end
    endtask

    task automatic sc_enable;
        wr(4'hF, 8'h00);
        tick({7'h03, 6'h00, 3'h6, 6'h31});
        irq(1'b0);
        flag(1'b1);
        wr(4'hE, 8'h00);
        wr(4'hE, 8'h08);
        flag(1'b0);
        tick({7'h04, 6'h00, 3'h6, 6'h31});
        wr(4'hF, 8'h08);
        repeat (200) @(negedge clk);
        irq(1'b1);
        wr(4'hF, 8'h00);
        irq(1'b0);
        flag(1'b1);
        wr(4'hE, 8'h00);
        wr(4'hF, 8'h09);
        tick({7'h05, 6'h00, 3'h6, 6'h31});
        irq(1'b0);
        flag(1'b0);
    endtask

    task automatic sc_now;
        wr(4'hF, 8'h08);
        tgt(8'h05, 8'h00, 8'h80);
        repeat (20) @(negedge clk);
        irq(1'b0);
        tick({7'h05, 6'h00, 3'h6, 6'h31});
        irq(1'b1);
        wr(4'hE, 8'h00);
        wr(4'hF, 8'h00);
        other_int_low = 1'b1;
        repeat (2) @(negedge clk);
        irq(1'b1);
        chk({7'h00, int_o}, 8'h00);
        other_int_low = 1'b0;
        repeat (2) @(negedge clk);
        irq(1'b0);
    endtask

    task automatic tally_and_finish;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        {rst_b, minute_tick, other_int_low} = 3'h0;
        {cur_minute, cur_hour, cur_weekday, cur_date} = 22'h000001;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        sc_regs();
        sc_week();
        sc_date();
        sc_enable();
        sc_now();
        tally_and_finish();
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
